// >>> inc/tpb_pkg.sv
// Shared constants and types for the six-channel timer pulse block.
// Assumes a 32-bit classic Wishbone master and a single 40 MHz clock.
package tpb_pkg;

  // ---------------------------------------------------------------
  // Sizes and clock
  // ---------------------------------------------------------------
  localparam int NCH = 6;
  localparam int CLK_HZ = 40_000_000;

  // ---------------------------------------------------------------
  // Address map: adr[7:5] channel slot, adr[4:2] register
  // ---------------------------------------------------------------
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_IO = 3'h1;
  localparam logic [2:0] OFS_STAT = 3'h2;
  localparam logic [2:0] OFS_CNT = 3'h3;
  localparam logic [2:0] OFS_START = 3'h0;
  localparam logic [2:0] START_SLOT = 3'h7;

  // ---------------------------------------------------------------
  // channel_control fields
  // ---------------------------------------------------------------
  localparam int PSC_LSB = 0;
  localparam int CLR_LSB = 3;
  localparam int MODE_LSB = 6;
  localparam int BUFA_BIT = 9;
  localparam logic [2:0] PSC_DIV4 = 3'h1;
  localparam logic [2:0] PSC_DIV16 = 3'h2;
  localparam logic [2:0] PSC_DIV64 = 3'h3;
  localparam logic [2:0] PSC_CASCADE = 3'h7;

  // ---------------------------------------------------------------
  // pin_io_control nibble and channel_status_reg bits
  // ---------------------------------------------------------------
  localparam int LVL_INIT_BIT = 2;
  localparam int LVL_CAP_BIT = 3;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam int STAT_OVF = 0;
  localparam int STAT_UNF = 1;
  localparam int STAT_DIR = 2;
  localparam int STAT_FLAG_LSB = 4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] IO_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  localparam logic [7:0] STAT_RST = 8'h04;
  localparam logic [5:0] START_RST = 6'h00;

  // Counting modes
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_PWM1 = 3'h1,
    MODE_PWM2 = 3'h2,
    MODE_PH1 = 3'h4,
    MODE_PH2 = 3'h5,
    MODE_PH3 = 3'h6,
    MODE_PH4 = 3'h7
  } chan_mode_t;

  // Wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

endpackage

// >>> logic/timer_pulse_block.sv
// Six-channel 16-bit timer: capture buffering, cascading, PWM, two-phase counting.
// Assumes a classic Wishbone master on ref_clk; encoder and capture pins are asynchronous.
//
// Behaviour
// - Buffered A capture moves old A into C in the same cycle
// - Cascade joins two 16-bit counters into one 32-bit counter
// - Cascade only 1 over 2 or 4 over 5, chosen by upper prescaler
// - Lower cascade half underflows only in two-phase counting
// - Channel 1 or 4 in two-phase mode ignores its cascade selection
// - Same-edge capture stores upper half in upper A, lower in lower A
// - Upper counter steps up on lower overflow, down on lower underflow
// - Compare match drives pin low, high or toggle
// - Compare match chosen as clear source sets the period
// - First PWM pairs A/B and C/D onto pins A and C
// - First PWM starts at A/C level; equal pair leaves output
// - Second PWM period clear returns outputs to initial level
// - Second PWM duty equal to period leaves output unchanged
// - Period register pin gives no second PWM output
// - Channels 0 and 3 have four registers, others two
// - Two-phase counting on 1,2,4,5 overrides prescaler and edge
// - Two-phase wraps set overflow/underflow; direction flag readable
// - Channels 1,5 use clock pins A,B; 2,4 use C,D
// - Mode 1 counts every edge of either phase
// - Mode 2 counts on A falling: up B high, down B low
// - Mode 3 up on A fall with B high, down on B fall with A high
// - Mode 4 counts only B edges by A level and polarity
// - Counter runs only while its start bit is set
// - Buffered compare match copies buffer into general register
`timescale 1ns/1ps

module timer_pulse_block
  import tpb_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Wishbone slave
  input  wire wb_req_t     wb_req,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Capture/compare pins, index 4*channel+register
  input  wire logic [23:0] capture_compare_pin_in,
  output logic [23:0]      capture_compare_pin_out,
  output logic [23:0]      capture_compare_pin_oe,
  // External clock pins A to D
  input  wire logic [3:0]  ext_clock_pin_in
);

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [15:0] ctrl [NCH];
  logic [15:0] io [NCH];
  logic [15:0] cnt [NCH];
  logic [15:0] gr [NCH][4];
  logic [7:0]  stat [NCH];
  logic [5:0]  start;
  logic [5:0]  psc_div;
  logic [2:0]  ext_s [4];
  logic [2:0]  cc_s [24];
  logic        ovf_ev [NCH];
  logic        unf_ev [NCH];
  logic        acc;
  logic        wr;
  logic [2:0]  bch;
  logic [2:0]  breg;
  logic [31:0] rd;

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                          input logic [3:0] sel);
    logic [15:0] m;
    m = {{8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  // Up/down decision of the four two-phase modes
  function automatic logic [1:0] phase_step(input chan_mode_t mode, input logic a, input logic b,
                                            input logic ra, input logic fa,
                                            input logic rb, input logic fb);
    logic up;
    logic dn;
    up = 1'b0;
    dn = 1'b0;
    case (mode)
      MODE_PH1: begin
        up = (a & rb) | (~a & fb) | (ra & ~b) | (fa & b);
        dn = (a & fb) | (~a & rb) | (ra & b) | (fa & ~b);
      end
      MODE_PH2: begin
        up = fa & b;
        dn = fa & ~b;
      end
      MODE_PH3: begin
        up = fa & b;
        dn = fb & a;
      end
      MODE_PH4: begin
        up = (a & rb) | (~a & fb);
        dn = (a & fb) | (~a & rb);
      end
      default: begin
        up = 1'b0;
        dn = 1'b0;
      end
    endcase
    return {up, dn};
  endfunction

  // Pin level after a compare match
  function automatic logic apply_level(input logic cur, input logic [3:0] f);
    case (f[1:0])
      ACT_LOW:    return 1'b0;
      ACT_HIGH:   return 1'b1;
      ACT_TOGGLE: return ~cur;
      default:    return cur;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers and prescaler
  // ---------------------------------------------------------------
  // Three-stage capture of asynchronous pins
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) ext_s[i] <= 3'h0;
      for (int i = 0; i < 24; i++) cc_s[i] <= 3'h0;
    end else begin
      for (int i = 0; i < 4; i++) ext_s[i] <= {ext_s[i][1:0], ext_clock_pin_in[i]};
      for (int i = 0; i < 24; i++) cc_s[i] <= {cc_s[i][1:0], capture_compare_pin_in[i]};
    end
  end

  // Free-running divider for internal count clocks
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) psc_div <= 6'h00;
    else psc_div <= psc_div + 6'h01;
  end

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  assign acc = wb_req.cyc & wb_req.stb;
  assign wr = acc & wb_req.we & wb_ack_o;
  assign bch = wb_req.adr[7:5];
  assign breg = wb_req.adr[4:2];

  // One-cycle acknowledge
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) wb_ack_o <= 1'b0;
    else wb_ack_o <= acc & ~wb_ack_o;
  end

  // Read data registered with the acknowledge
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) wb_dat_o <= 32'h0000_0000;
    else if (acc & ~wb_ack_o) wb_dat_o <= rd;
  end

  // Read multiplexer, unmapped words read zero
  always_comb begin
    rd = 32'h0000_0000;
    if (bch == START_SLOT) begin
      if (breg == OFS_START) rd[5:0] = start;
    end else if (bch < 3'(NCH)) begin
      case (breg)
        OFS_CTRL: rd[15:0] = ctrl[bch];
        OFS_IO:   rd[15:0] = io[bch];
        OFS_STAT: rd[7:0] = stat[bch];
        OFS_CNT:  rd[15:0] = cnt[bch];
        default: begin
          if (bch == 3'h0 || bch == 3'h3 || !breg[1]) rd[15:0] = gr[bch][breg[1:0]];
        end
      endcase
    end
  end

  // Control, pin control and shared start register writes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NCH; i++) begin
        ctrl[i] <= CTRL_RST;
        io[i] <= IO_RST;
      end
      start <= START_RST;
    end else if (wr) begin
      if (bch == START_SLOT && breg == OFS_START)
        start <= 6'(merge16({10'h000, start}, wb_req.dat[15:0], wb_req.sel));
      for (int i = 0; i < NCH; i++) begin
        if (bch == 3'(i) && breg == OFS_CTRL) ctrl[i] <= merge16(ctrl[i], wb_req.dat[15:0], wb_req.sel);
        if (bch == 3'(i) && breg == OFS_IO) io[i] <= merge16(io[i], wb_req.dat[15:0], wb_req.sel);
      end
    end
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    localparam bit HAS_CD = (ch == 0) || (ch == 3);
    localparam bit UPPER = (ch == 1) || (ch == 4);
    localparam int LO = UPPER ? ch + 1 : ch;
    localparam int PA = ((ch == 1) || (ch == 5)) ? 0 : 2;
    chan_mode_t  mode;
    logic [2:0]  csel;
    logic [1:0]  p;
    logic [1:0]  ph;
    logic [3:0]  match;
    logic [3:0]  cap;
    logic [3:0]  is_cap;
    logic [3:0]  live;
    logic [7:0]  clrm;
    logic        is_ph;
    logic        casc;
    logic        tick;
    logic        inc;
    logic        dec;
    logic        clr;
    logic        wr_ch;
    logic [3:0]  pin_level;
    logic [3:0]  pin_drive;

    assign mode = chan_mode_t'(ctrl[ch][MODE_LSB +: 3]);
    assign csel = ctrl[ch][CLR_LSB +: 3];
    assign p = 2'(csel - 3'h1);
    assign is_ph = !HAS_CD && ctrl[ch][MODE_LSB + 2];
    assign casc = UPPER && ctrl[ch][PSC_LSB +: 3] == PSC_CASCADE;
    assign wr_ch = wr && bch == 3'(ch);
    assign clrm = (wr_ch && breg == OFS_STAT) ? {wb_req.dat[7:4], 2'b00, wb_req.dat[1:0]} : 8'h00;

    // Encoder phases from the synchronised clock pins
    assign ph = phase_step(mode, ext_s[PA][1], ext_s[PA + 1][1],
                           ext_s[PA][1] & ~ext_s[PA][2], ~ext_s[PA][1] & ext_s[PA][2],
                           ext_s[PA + 1][1] & ~ext_s[PA + 1][2], ~ext_s[PA + 1][1] & ext_s[PA + 1][2]);

    // Count source selection
    always_comb begin
      case (ctrl[ch][PSC_LSB +: 3])
        PSC_DIV4:  tick = psc_div[1:0] == 2'h3;
        PSC_DIV16: tick = psc_div[3:0] == 4'hF;
        PSC_DIV64: tick = psc_div == 6'h3F;
        default:   tick = 1'b1;
      endcase
      if (is_ph) begin
        inc = ph[1];
        dec = ph[0];
      end else if (casc) begin
        inc = ovf_ev[LO];
        dec = unf_ev[LO];
      end else begin
        inc = tick;
        dec = 1'b0;
      end
      inc = inc & start[ch];
      dec = dec & start[ch];
    end

    assign ovf_ev[ch] = inc && cnt[ch] == 16'hFFFF;
    assign unf_ev[ch] = dec && cnt[ch] == 16'h0000;

    // Compare matches and captures per general register
    always_comb begin
      for (int k = 0; k < 4; k++) begin
        live[k] = (k < 2) || (HAS_CD && !ctrl[ch][BUFA_BIT + (k % 2)]);
        is_cap[k] = io[ch][4 * k + LVL_CAP_BIT];
        match[k] = live[k] && !is_cap[k] && (inc || dec) && cnt[ch] == gr[ch][k];
        cap[k] = live[k] && is_cap[k] &&
                 ((io[ch][4 * k] && cc_s[4 * ch + k][1] && !cc_s[4 * ch + k][2]) ||
                  (io[ch][4 * k + 1] && !cc_s[4 * ch + k][1] && cc_s[4 * ch + k][2]));
      end
    end

    assign clr = csel != 3'h0 && csel <= 3'h4 && (match[p] || cap[p]);

    // Counter
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) cnt[ch] <= CNT_RST;
      else if (wr_ch && breg == OFS_CNT) cnt[ch] <= merge16(cnt[ch], wb_req.dat[15:0], wb_req.sel);
      else if (clr) cnt[ch] <= 16'h0000;
      else if (inc) cnt[ch] <= cnt[ch] + 16'h0001;
      else if (dec) cnt[ch] <= cnt[ch] - 16'h0001;
    end

    // General registers with capture and buffer transfers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        for (int k = 0; k < 4; k++) gr[ch][k] <= GR_RST;
      end else begin
        for (int k = 0; k < 4; k++) begin
          if (cap[k]) begin
            gr[ch][k] <= cnt[ch];
            if (k < 2 && HAS_CD && ctrl[ch][BUFA_BIT + k]) gr[ch][(k + 2) % 4] <= gr[ch][k];
          end else if (match[k] && k < 2 && HAS_CD && ctrl[ch][BUFA_BIT + (k % 2)]) begin
            gr[ch][k] <= gr[ch][(k + 2) % 4];
          end
        end
        if (wr_ch && breg[2] && (HAS_CD || !breg[1]))
          gr[ch][breg[1:0]] <= merge16(gr[ch][breg[1:0]], wb_req.dat[15:0], wb_req.sel);
      end
    end

    // Status flags, set wins over write-one clear
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        stat[ch] <= STAT_RST;
      end else begin
        stat[ch][STAT_FLAG_LSB +: 4] <= (stat[ch][STAT_FLAG_LSB +: 4] & ~clrm[7:4]) | match | cap;
        stat[ch][STAT_OVF] <= (stat[ch][STAT_OVF] & ~clrm[STAT_OVF]) | ovf_ev[ch];
        stat[ch][STAT_UNF] <= (stat[ch][STAT_UNF] & ~clrm[STAT_UNF]) | unf_ev[ch];
        if (is_ph && (inc || dec)) stat[ch][STAT_DIR] <= inc;
      end
    end

    // Pin drive for compare and PWM outputs
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        pin_level <= 4'h0;
        pin_drive <= 4'h0;
      end else begin
        for (int k = 0; k < 4; k++) begin
          pin_drive[k] <= live[k] && !is_cap[k] &&
            !(mode == MODE_PWM1 && k[0]) &&
            !(mode == MODE_PWM2 && csel != 3'h0 && p == 2'(k));
          if (!start[ch]) begin
            pin_level[k] <= io[ch][4 * k + LVL_INIT_BIT];
          end else begin
            case (mode)
              MODE_PWM1: begin
                if (!k[0] && gr[ch][k] != gr[ch][k | 1]) begin
                  if (match[k])
                    pin_level[k] <= apply_level(pin_level[k], io[ch][4 * k +: 4]);
                  else if (match[k | 1])
                    pin_level[k] <= apply_level(pin_level[k], io[ch][4 * (k | 1) +: 4]);
                end
              end
              MODE_PWM2: begin
                if (!(csel != 3'h0 && gr[ch][k] == gr[ch][p])) begin
                  if (clr)
                    pin_level[k] <= io[ch][4 * k + LVL_INIT_BIT];
                  else if (match[k])
                    pin_level[k] <= apply_level(pin_level[k], io[ch][4 * k +: 4]);
                end
              end
              default: begin
                if (match[k])
                  pin_level[k] <= apply_level(pin_level[k], io[ch][4 * k +: 4]);
              end
            endcase
          end
        end
      end
    end

    // Channel pin registers onto the shared output vectors
    assign capture_compare_pin_out[4 * ch +: 4] = pin_level;
    assign capture_compare_pin_oe[4 * ch +: 4] = pin_drive;

    // Checks on this channel
    a_start_gate: assert property (!start[ch] && !clr && !(wr_ch && breg == OFS_CNT) |=> $stable(cnt[ch]))
      else $error("counter stepped while stopped");
    a_under_phase: assert property (unf_ev[ch] && !casc |-> is_ph)
      else $error("underflow outside two-phase mode");
    a_phase_source: assert property (is_ph && start[ch] && ph[1] && !clr && !(wr_ch && breg == OFS_CNT)
                                     |=> cnt[ch] == $past(cnt[ch]) + 16'h0001)
      else $error("two-phase count not from encoder");
    a_dir_down: assert property (is_ph && dec && !inc |=> !stat[ch][STAT_DIR])
      else $error("direction flag not down");
    a_ovf_flag: assert property (ovf_ev[ch] |=> stat[ch][STAT_OVF] ##1
                                 (stat[ch][STAT_OVF] || $past(clrm[STAT_OVF])))
      else $error("overflow flag lost");
    a_pwm1_equal: assert property (mode == MODE_PWM1 && start[ch] && gr[ch][0] == gr[ch][1]
                                   |=> $stable(capture_compare_pin_out[4 * ch]))
      else $error("equal pair changed output");
    a_pwm2_restart: assert property (mode == MODE_PWM2 && start[ch] && clr && p != 2'h0 &&
                                     gr[ch][0] != gr[ch][p]
                                     |=> capture_compare_pin_out[4 * ch] == $past(io[ch][LVL_INIT_BIT]))
      else $error("output not restored at period");
    if (UPPER) begin : g_casc
      a_cascade_step: assert property (casc && !is_ph && ovf_ev[LO] && !clr &&
                                       !(wr_ch && breg == OFS_CNT)
                                       |=> cnt[ch] == $past(cnt[ch]) + 16'h0001)
        else $error("upper half missed carry");
    end
    if (HAS_CD) begin : g_buf
      a_buf_capture: assert property (cap[0] && ctrl[ch][BUFA_BIT] && !(wr_ch && breg[2])
                                      |=> gr[ch][2] == $past(gr[ch][0]) && gr[ch][0] == $past(cnt[ch]))
        else $error("capture buffer not shifted");
    end
  end

endmodule

// >>> verification/quad_encoder.sv
// Quadrature encoder model driving one A/B pair of external clock pins.
// Assumes the bench calls move() from its main sequence; phases are plain levels.
`timescale 1ns/1ps

module quad_encoder (
  // Clock
  input  wire logic ref_clk,
  // Encoder phases
  output logic      phase_a,
  output logic      phase_b
);
  logic [1:0] pos = 2'h0;

  // Gray position to phase levels, A leads B when moving forward
  assign phase_a = (pos == 2'h1) || (pos == 2'h2);
  assign phase_b = pos[1];

  // One quarter step every four clocks, then let the input synchroniser settle
  task automatic move(input int quarters, input logic fwd);
    repeat (quarters) begin
      repeat (4) @(posedge ref_clk);
      pos <= fwd ? pos + 2'h1 : pos - 2'h1;
    end
    repeat (8) @(posedge ref_clk);
  endtask
endmodule

// >>> verification/tb.sv
// Self-checking bench for the timer pulse block over classic Wishbone.
// Assumes the encoder model drives the external clock pins; capture pins come from here.
`timescale 1ns/1ps

module tb
  import tpb_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  wb_req_t     req = '0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [23:0] cc_in = 24'h000000;
  logic [23:0] cc_out;
  logic [23:0] cc_oe;
  logic [3:0]  ext_pins;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic [15:0] cap_a;
  logic [7:0]  high_cnt;
  chan_mode_t  modes [4] = '{MODE_PH1, MODE_PH2, MODE_PH3, MODE_PH4};
  logic [15:0] exp_fwd [4] = '{16'h0008, 16'h0002, 16'h0002, 16'h0004};
  logic [15:0] exp_back [4] = '{16'hFFFC, 16'hFFFF, 16'hFFFF, 16'hFFFE};

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  timer_pulse_block u_dut (
    .ref_clk                 (ref_clk),
    .sys_rst                 (sys_rst),
    .wb_req                  (req),
    .wb_dat_o                (wb_dat_o),
    .wb_ack_o                (wb_ack_o),
    .capture_compare_pin_in  (cc_in),
    .capture_compare_pin_out (cc_out),
    .capture_compare_pin_oe  (cc_oe),
    .ext_clock_pin_in        (ext_pins)
  );
  quad_encoder enc_ab (.ref_clk(ref_clk), .phase_a(ext_pins[0]), .phase_b(ext_pins[1]));
  quad_encoder enc_cd (.ref_clk(ref_clk), .phase_a(ext_pins[2]), .phase_b(ext_pins[3]));

  // ---------------------------------------------------------------
  // Bus tasks and comparisons
  // ---------------------------------------------------------------
  function automatic logic [7:0] adr(input int ch, input logic [2:0] r);
    adr = {ch[2:0], r, 2'h0};
  endfunction

  // One classic cycle, held until ack is sampled high
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [15:0] wd);
    @(posedge ref_clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: {16'h0000, wd}};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    req <= '0;
  endtask

  task automatic wr(input int ch, input logic [2:0] r, input logic [15:0] d);
    wb_cycle(1'b1, adr(ch, r), d);
  endtask

  task automatic start(input logic [5:0] m);
    wb_cycle(1'b1, {START_SLOT, OFS_START, 2'h0}, {10'h000, m});
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input int ch, input logic [2:0] r, input logic [31:0] exp);
    wb_cycle(1'b0, adr(ch, r), 16'h0000);
    chk(rd, exp);
  endtask

  // High cycles of pin A of channel 0 over ten whole periods
  task automatic measure(input logic [7:0] exp);
    repeat (20) @(posedge ref_clk);
    high_cnt = 8'h00;
    repeat (100) begin
      @(posedge ref_clk);
      high_cnt = high_cnt + 8'(cc_out[0]);
    end
    chk({24'h000000, high_cnt}, {24'h000000, exp});
  endtask

  task automatic finish_test;
    $display("Checks: %0d mismatches: %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test;
    end
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Reset values, missing registers and an unmapped slot
    rchk(0, OFS_CTRL, 32'h00000000);
    rchk(0, OFS_STAT, 32'h00000004);
    rchk(0, 3'h4, 32'h0000FFFF);
    rchk(6, OFS_CTRL, 32'h00000000);
    wr(1, 3'h6, 16'h1234);
    rchk(1, 3'h6, 32'h00000000);
    repeat (20) @(posedge ref_clk);
    rchk(0, OFS_CNT, 32'h00000000);
    // First PWM: period 10 by A clear, low at A, high at B
    wr(0, 3'h4, 16'h0009);
    wr(0, 3'h5, 16'h0003);
    wr(0, OFS_IO, 16'h0021);
    wr(0, OFS_CTRL, 16'h0048);
    start(6'h01);
    measure(8'd60);
    chk({30'h0, cc_oe[1:0]}, 32'h00000001);
    start(6'h00);
    wr(0, 3'h5, 16'h0009);
    start(6'h01);
    measure(8'd0);
    start(6'h00);
    // Second PWM: period 10 by B clear, A starts high and goes low at 3
    wr(0, 3'h4, 16'h0003);
    wr(0, 3'h5, 16'h0009);
    wr(0, OFS_IO, 16'h0015);
    wr(0, OFS_CTRL, 16'h0090);
    start(6'h01);
    measure(8'd40);
    chk({30'h0, cc_oe[1:0]}, 32'h00000001);
    start(6'h00);
    wr(0, 3'h4, 16'h0009);
    start(6'h01);
    measure(8'd100);
    // Buffered compare: A match loads C into A
    start(6'h00);
    wr(0, 3'h6, 16'h0004);
    wr(0, OFS_CTRL, 16'h0208);
    start(6'h01);
    repeat (20) @(posedge ref_clk);
    rchk(0, 3'h4, 32'h00000004);
    start(6'h00);
    // Every two-phase mode on channel 1, cascade selection left set
    for (int i = 0; i < 4; i++) begin
      wr(1, OFS_CTRL, {7'h00, modes[i], 6'h07});
      wr(1, OFS_CNT, 16'h0000);
      wr(1, OFS_STAT, 16'h00FF);
      start(6'h02);
      enc_ab.move(8, 1'b1);
      rchk(1, OFS_CNT, {16'h0000, exp_fwd[i]});
      enc_ab.move(12, 1'b0);
      rchk(1, OFS_CNT, {16'h0000, exp_back[i]});
      wb_cycle(1'b0, adr(1, OFS_STAT), 16'h0000);
      chk(rd & 32'h00000007, 32'h00000002);
    end
    // Cascade of channel 1 over channel 2, lower half on pins C and D
    wr(1, OFS_CTRL, 16'h0007);
    wr(2, OFS_CTRL, {7'h00, MODE_PH1, 6'h00});
    wr(2, OFS_CNT, 16'hFFFE);
    wr(1, OFS_CNT, 16'h0005);
    wr(2, OFS_STAT, 16'h00FF);
    start(6'h06);
    enc_cd.move(4, 1'b1);
    rchk(2, OFS_CNT, 32'h00000002);
    rchk(1, OFS_CNT, 32'h00000006);
    wb_cycle(1'b0, adr(2, OFS_STAT), 16'h0000);
    chk(rd & 32'h00000001, 32'h00000001);
    enc_cd.move(4, 1'b0);
    rchk(2, OFS_CNT, 32'h0000FFFE);
    rchk(1, OFS_CNT, 32'h00000005);
    // Same-edge capture on both halves of the cascade
    wr(1, OFS_IO, 16'h0009);
    wr(2, OFS_IO, 16'h0009);
    cc_in[4] <= 1'b1;
    cc_in[8] <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rchk(1, 3'h4, 32'h00000005);
    rchk(2, 3'h4, 32'h0000FFFE);
    // Buffered capture on channel 3, rising edges of pin A
    start(6'h00);
    wr(3, OFS_CTRL, 16'h0200);
    wr(3, OFS_IO, 16'h0009);
    start(6'h08);
    @(posedge ref_clk);
    cc_in[12] <= 1'b1;
    repeat (10) @(posedge ref_clk);
    wb_cycle(1'b0, adr(3, 3'h4), 16'h0000);
    cap_a = rd[15:0];
    rchk(3, 3'h6, 32'h0000FFFF);
    cc_in[12] <= 1'b0;
    repeat (10) @(posedge ref_clk);
    cc_in[12] <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rchk(3, 3'h6, {16'h0000, cap_a});
    finish_test;
  end
endmodule
